// ---- iofw_watchdog.sv ----
// io failsafe watchdog top
// How it works
// R1 - host must service the watchdog regularly or it trips.
// R2 - on trip every pin detaches and becomes a pulled-high input.
// R3 - while tripped, host communication is blocked.
// R4 - trip changes pin configuration only; module logic keeps running.
// R5 - clearing the trip restores communication and load-time pin ownership.
// R6 - trip flag is readable; host clears it to restart.
// R7 - timeout is a 32-bit nanosecond value, one second at init.
// R8 - trip when time since last service exceeds the timeout.
// R9 - each service while running restarts the timer for a full timeout.
// R10 - host should service from its periodic servo loop.
// R11 - pins owned by no active module act as general purpose pins.
// R12 - elapsed time advances one clock period per cycle; trip held until host clears it.
`timescale 1ns/1ps
`include "iofw_consts.svh"
module iofw_watchdog #(
   parameter int PINS = `IOFW_PIN_COUNT
) (
   // clock and reset
   input  wire logic                  sys_clk_in,
   input  wire logic                  reset_in,
   // host control
   input  wire logic                  service_in,
   input  wire logic                  timeout_wr_in,
   input  wire logic [31:0]           trip_timeout_nanoseconds_in,
   input  wire logic                  trip_clear_in,
   output logic      [31:0]           trip_timeout_nanoseconds_out,
   output logic                       tripped_out,
   // host communication gate
   input  wire logic                  host_req_in,
   output logic                       host_req_out,
   // pin configuration
   input  wire logic [PINS-1:0]       owner_module_in,
   input  wire logic [PINS-1:0]       module_out_in,
   input  wire logic [PINS-1:0]       module_oe_n_in,
   input  wire logic [PINS-1:0]       gpio_out_in,
   input  wire logic [PINS-1:0]       gpio_oe_n_in,
   output logic      [PINS-1:0]       general_purpose_pin_out,
   output logic      [PINS-1:0]       general_purpose_pin_oe_n_out,
   output logic      [PINS-1:0]       general_purpose_pin_pullup_out
);
   import iofw_pkg::*;

   // one clock period at the width of the elapsed counter
   localparam logic [32:0] STEP_NS = {1'b0, `IOFW_CLK_PERIOD_NS};

   iofw_regs_type r_q;
   iofw_regs_type r_d;

   // one bit wider than the limit, so a full-scale limit still expires
   logic [32:0]     limit_ns;
   logic            overdue;
   logic            tripped;
   logic [PINS-1:0] cfg_out;
   logic [PINS-1:0] cfg_oe_n;

   assign limit_ns = {1'b0, r_q.trip_timeout_nanoseconds};
   assign overdue  = (r_q.elapsed_ns > limit_ns); // R8
   assign tripped  = (r_q.state == IOFW_TRIPPED);

   always_comb begin
      r_d = r_q;
      if (timeout_wr_in) begin
         r_d.trip_timeout_nanoseconds = trip_timeout_nanoseconds_in; // R7
      end
      unique case (r_q.state)
         IOFW_RUN: begin
            if (service_in) begin
               r_d.elapsed_ns = 33'h0; // R9
            end else if (overdue) begin
               r_d.state = IOFW_TRIPPED; // R8
            end else begin
               r_d.elapsed_ns = r_q.elapsed_ns + STEP_NS; // R12
            end
         end
         IOFW_TRIPPED: begin
            // service is ignored; only the host clear leaves
            if (trip_clear_in) begin
               r_d.state      = IOFW_RUN; // R6 R12
               r_d.elapsed_ns = 33'h0;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         r_q.state                    <= IOFW_RUN;
         r_q.trip_timeout_nanoseconds <= `IOFW_TIMEOUT_INIT_NS; // R7
         r_q.elapsed_ns               <= 33'h0;
      end else begin
         r_q <= r_d;
      end
   end

   // host side
   assign tripped_out                  = tripped; // R6
   assign trip_timeout_nanoseconds_out = r_q.trip_timeout_nanoseconds;
   assign host_req_out                 = host_req_in & ~tripped; // R3 R5

   // module instances stay untouched; only the mux sees the trip
   iofw_pin_mux #(
      .PINS (PINS)
   ) u_mux (
      .tripped_in      (tripped), // R4
      .owner_module_in (owner_module_in),
      .module_out_in   (module_out_in),
      .module_oe_n_in  (module_oe_n_in),
      .gpio_out_in     (gpio_out_in),
      .gpio_oe_n_in    (gpio_oe_n_in),
      .pin_out         (general_purpose_pin_out),
      .pin_oe_n_out    (general_purpose_pin_oe_n_out),
      .pin_pullup_out  (general_purpose_pin_pullup_out)
   );

   // load-time pin configuration, for the checks below
   assign cfg_out  = (owner_module_in & module_out_in) | (~owner_module_in & gpio_out_in);
   assign cfg_oe_n = (owner_module_in & module_oe_n_in) | (~owner_module_in & gpio_oe_n_in);

   // timer expired with no service pending
   sequence overdue_s;
      r_q.state == IOFW_RUN && !service_in && overdue;
   endsequence

   // timer still counting up
   sequence counting_s;
      r_q.state == IOFW_RUN && !service_in && !overdue;
   endsequence

   // service taken while running
   sequence serviced_s;
      service_in && !tripped;
   endsequence

   // timer at zero, no trip one cycle on
   sequence restarted_s;
      (r_q.elapsed_ns == 33'h0) ##1 !tripped_out;
   endsequence

   // run to trip with no timeout write on the way
   sequence trip_edge_s;
      (!tripped && !timeout_wr_in) ##1 tripped;
   endsequence

   // trip cleared by the host
   sequence clear_edge_s;
      tripped ##1 !tripped;
   endsequence

   // timer
   trip_on_expiry_a : assert property (@(posedge sys_clk_in) disable iff (reset_in) // R8
      overdue_s |=> tripped_out)
      else $error("no trip after expiry");

   no_early_trip_a : assert property (@(posedge sys_clk_in) disable iff (reset_in) // R9
      (!tripped && !overdue) |=> !tripped_out)
      else $error("trip before the timeout passed");

   service_restart_a : assert property (@(posedge sys_clk_in) disable iff (reset_in) // R9
      serviced_s |=> restarted_s)
      else $error("service did not restart timer");

   elapsed_step_a : assert property (@(posedge sys_clk_in) disable iff (reset_in) // R12
      counting_s |=> r_q.elapsed_ns == $past(r_q.elapsed_ns) + STEP_NS)
      else $error("elapsed time not advanced by one period");

   // trip flag
   trip_hold_a : assert property (@(posedge sys_clk_in) disable iff (reset_in) // R12
      (tripped && !trip_clear_in) |=> tripped)
      else $error("trip dropped without clear");

   service_ignored_a : assert property (@(posedge sys_clk_in) disable iff (reset_in) // R12
      (tripped && service_in && !trip_clear_in) |=> tripped_out)
      else $error("service left the tripped state");

   trip_clear_a : assert property (@(posedge sys_clk_in) disable iff (reset_in) // R6
      (tripped && trip_clear_in) |=> !tripped_out)
      else $error("clear ignored");

   // host gate
   comm_block_a : assert property (@(posedge sys_clk_in) disable iff (reset_in) // R3
      tripped |-> !host_req_out)
      else $error("host traffic while tripped");

   comm_resume_a : assert property (@(posedge sys_clk_in) disable iff (reset_in) // R5
      (!tripped && host_req_in) |-> host_req_out)
      else $error("host traffic blocked");

   // pins
   pins_float_a : assert property (@(posedge sys_clk_in) disable iff (reset_in) // R2
      tripped |-> (&general_purpose_pin_oe_n_out && &general_purpose_pin_pullup_out))
      else $error("pin driven while tripped");

   pins_restore_a : assert property (@(posedge sys_clk_in) disable iff (reset_in) // R5
      clear_edge_s |-> (general_purpose_pin_oe_n_out == cfg_oe_n && general_purpose_pin_out == cfg_out))
      else $error("pins not restored after clear");

   run_pins_a : assert property (@(posedge sys_clk_in) disable iff (reset_in) // R5
      !tripped |-> (general_purpose_pin_oe_n_out == cfg_oe_n && general_purpose_pin_out == cfg_out))
      else $error("pin not on its load-time owner");

   run_pullup_off_a : assert property (@(posedge sys_clk_in) disable iff (reset_in) // R5
      !tripped |-> general_purpose_pin_pullup_out == '0)
      else $error("pull-up left on while running");

   gpio_owner_a : assert property (@(posedge sys_clk_in) disable iff (reset_in) // R11
      (!tripped && owner_module_in == '0) |->
         (general_purpose_pin_oe_n_out == gpio_oe_n_in && general_purpose_pin_out == gpio_out_in))
      else $error("free pin not general purpose");

   // timeout register
   timeout_write_a : assert property (@(posedge sys_clk_in) disable iff (reset_in) // R7
      timeout_wr_in |=> trip_timeout_nanoseconds_out == $past(trip_timeout_nanoseconds_in))
      else $error("timeout write lost");

   timeout_hold_a : assert property (@(posedge sys_clk_in) disable iff (reset_in) // R7
      !timeout_wr_in |=> $stable(trip_timeout_nanoseconds_out))
      else $error("timeout changed without a write");

   trip_keeps_cfg_a : assert property (@(posedge sys_clk_in) disable iff (reset_in) // R4
      trip_edge_s |-> $stable(trip_timeout_nanoseconds_out))
      else $error("trip disturbed the timeout setting");
endmodule // iofw_watchdog

// ---- iofw_consts.svh ----
// constants for the io failsafe watchdog
`ifndef IOFW_CONSTS_SVH
`define IOFW_CONSTS_SVH
`define IOFW_CLK_PERIOD_NS      32'd8
`define IOFW_TIMEOUT_INIT_NS    32'd1000000000
`define IOFW_PIN_COUNT          72
`define IOFW_OWNER_GPIO         1'b0
`define IOFW_OWNER_MODULE       1'b1
`endif

// ---- iofw_pkg.sv ----
// types for the io failsafe watchdog
package iofw_pkg;
   typedef enum logic {
      IOFW_RUN,
      IOFW_TRIPPED
   } iofw_state_type;

   typedef struct packed {
      iofw_state_type state;
      logic [31:0]    trip_timeout_nanoseconds;
      logic [32:0]    elapsed_ns;
   } iofw_regs_type;
endpackage

// ---- iofw_pin_mux.sv ----
// per-pin ownership and failsafe mux
`timescale 1ns/1ps
module iofw_pin_mux #(
   parameter int PINS = 72
) (
   // failsafe
   input  wire logic            tripped_in,
   // load-time configuration
   input  wire logic [PINS-1:0] owner_module_in,
   // module instance side
   input  wire logic [PINS-1:0] module_out_in,
   input  wire logic [PINS-1:0] module_oe_n_in,
   // general purpose side
   input  wire logic [PINS-1:0] gpio_out_in,
   input  wire logic [PINS-1:0] gpio_oe_n_in,
   // pins
   output logic      [PINS-1:0] pin_out,
   output logic      [PINS-1:0] pin_oe_n_out,
   output logic      [PINS-1:0] pin_pullup_out
);
   genvar g;
   for (g = 0; g < PINS; g++) begin : g_pin
      always_comb begin
         if (tripped_in) begin
            pin_out[g]        = 1'b1; // R2
            pin_oe_n_out[g]   = 1'b1; // R2
            pin_pullup_out[g] = 1'b1; // R2
         end else if (owner_module_in[g]) begin
            pin_out[g]        = module_out_in[g]; // R5
            pin_oe_n_out[g]   = module_oe_n_in[g];
            pin_pullup_out[g] = 1'b0;
         end else begin
            pin_out[g]        = gpio_out_in[g]; // R11
            pin_oe_n_out[g]   = gpio_oe_n_in[g]; // R11
            pin_pullup_out[g] = 1'b0;
         end
      end
   end
endmodule // iofw_pin_mux

// ---- iofw_host.sv ----
// host model: periodic service and trip clear
`timescale 1ns/1ps
module iofw_host #(
   parameter int PERIOD = 5
) (
   input  wire logic sys_clk_in,
   input  wire logic pet_en_in,
   input  wire logic clear_in,
   output logic      service_out,
   output logic      trip_clear_out
);
   int cnt = 0;
   initial begin
      service_out = 1'b0;
      trip_clear_out = 1'b0;
   end
   // drive off the falling edge, one pulse per period
   always @(negedge sys_clk_in) begin
      cnt = (cnt + 1) % PERIOD;
      service_out <= pet_en_in && (cnt == 0);
      trip_clear_out <= clear_in;
   end
endmodule // iofw_host

// ---- io_failsafe_watchdog_test.sv ----
// testbench for the io failsafe watchdog
`timescale 1ns/1ps
`define CHK(n, e, a) begin \
   checked++; \
   if ((a) !== (e)) begin \
      error_cnt++; \
      $display("MISMATCH %s exp %h got %h", n, e, a); \
   end \
end
module io_failsafe_watchdog_test;
   logic sys_clk_in = 1'b0, reset_in = 1'b1, wr = 1'b0, req = 1'b1, pet = 1'b0, clr = 1'b0;
   logic [31:0] ns_in = 32'h0, ns_out;
   logic svc, tclr, tripped, req_out;
   logic [3:0] p_out, p_oe_n, p_pu;
   logic [3:0] own = 4'h5;
   int error_cnt = 0, checked = 0, i;
   initial forever #4 sys_clk_in = ~sys_clk_in;
   iofw_host host (.sys_clk_in(sys_clk_in), .pet_en_in(pet), .clear_in(clr), .service_out(svc), .trip_clear_out(tclr));
   iofw_watchdog #(.PINS(4)) dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .service_in(svc),
      .timeout_wr_in(wr), .trip_timeout_nanoseconds_in(ns_in), .trip_clear_in(tclr),
      .trip_timeout_nanoseconds_out(ns_out), .tripped_out(tripped), .host_req_in(req),
      .host_req_out(req_out), .owner_module_in(own), .module_out_in(4'h3), .module_oe_n_in(4'h0),
      .gpio_out_in(4'hc), .gpio_oe_n_in(4'ha), .general_purpose_pin_out(p_out),
      .general_purpose_pin_oe_n_out(p_oe_n), .general_purpose_pin_pullup_out(p_pu));
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic t_write();
      `CHK("timeout init", 32'd1000000000, ns_out)
      `CHK("tripped init", 1'b0, tripped)
      wr = 1'b1;
      ns_in = 32'd80;
      @(negedge sys_clk_in) wr = 1'b0;
      @(negedge sys_clk_in);
      `CHK("timeout rw", 32'd80, ns_out)
   endtask
   task automatic t_serviced();
      pet <= 1'b1;
      repeat (60) @(negedge sys_clk_in);
      `CHK("no trip", 1'b0, tripped)
      `CHK("pins run", 4'h9, p_out)
   endtask
   task automatic t_gpio();
      own = 4'h0;
      req = 1'b0;
      @(negedge sys_clk_in);
      `CHK("free pins", 4'hc, p_out)
      `CHK("free oe_n", 4'ha, p_oe_n)
      `CHK("req gated", 1'b0, req_out)
      own = 4'h5;
      req = 1'b1;
      @(negedge sys_clk_in);
      `CHK("owned pins", 4'h9, p_out)
      `CHK("owned oe_n", 4'ha, p_oe_n)
   endtask
   task automatic t_trip();
      pet <= 1'b0;
      repeat (5) @(negedge sys_clk_in);
      `CHK("early", 1'b0, tripped)
      for (i = 0; i < 20 && tripped !== 1'b1; i++) @(negedge sys_clk_in);
      `CHK("trip", 1'b1, tripped)
      `CHK("oe_n", 4'hf, p_oe_n)
      `CHK("pullup", 4'hf, p_pu)
      `CHK("req", 1'b0, req_out)
      pet <= 1'b1;
      repeat (12) @(negedge sys_clk_in);
      `CHK("held", 1'b1, tripped)
   endtask
   task automatic t_clear();
      clr <= 1'b1;
      @(negedge sys_clk_in) clr <= 1'b0;
      @(negedge sys_clk_in);
      `CHK("cleared", 1'b0, tripped)
      `CHK("req back", 1'b1, req_out)
      `CHK("pin restore", 4'h9, p_out)
      `CHK("oe restore", 4'ha, p_oe_n)
   endtask
   task automatic t_reset();
      wr = 1'b1;
      ns_in = 32'd160;
      @(negedge sys_clk_in) wr = 1'b0;
      reset_in = 1'b1;
      @(negedge sys_clk_in);
      `CHK("reset timeout", 32'd1000000000, ns_out)
      `CHK("reset tripped", 1'b0, tripped)
      reset_in = 1'b0;
      repeat (2) @(negedge sys_clk_in);
      `CHK("timeout kept", 32'd1000000000, ns_out)
      `CHK("run after reset", 1'b0, tripped)
   endtask
   initial begin
      repeat (8) @(negedge sys_clk_in);
      reset_in = 1'b0;
      @(negedge sys_clk_in);
      t_write();
      t_serviced();
      t_gpio();
      t_trip();
      t_clear();
      t_reset();
      tally_and_finish();
   end
   initial begin
      #20000;
      error_cnt++;
      tally_and_finish();
   end
endmodule // io_failsafe_watchdog_test
